/* File: verilog/cb_params.svh */
// constants shared by both ends of the clock buffer management port
`ifndef CB_PARAMS_SVH
`define CB_PARAMS_SVH

// register indices
`define CB_REG_OE 8'h00
`define CB_REG_MODE 8'h01
`define CB_REG_EDGE 8'h02
`define CB_REG_FB 8'h03
`define CB_REG_RSV 8'h04
`define CB_REG_REV 8'h05
`define CB_REG_DEV 8'h06
`define CB_REG_LEN 8'h07
// reset values and fixed read values
`define CB_OE_RST 8'hFF
`define CB_EDGE_RST 8'hFF
`define CB_AMP_RST 2'h2
`define CB_LEN_RST 5'h08
`define CB_ALL_ONES 8'hFF
`define CB_MODE_RSV 1'h1
`define CB_FB_RSV 7'h03
// identity codes, values arbitrary
`define CB_REV_CODE 4'hA
`define CB_MAKER_CODE 4'h5
`define CB_CLASS_CODE 2'h2
`define CB_PART_CODE 6'h15
// target addresses per select pin level, values arbitrary
`define CB_ADDR_LO 7'h10
`define CB_ADDR_MID 7'h11
`define CB_ADDR_HI 7'h12
// tri-level pin codes and mode codes
`define CB_PIN_LO 2'h0
`define CB_PIN_MID 2'h1
`define CB_PIN_HI 2'h3
`define CB_MODE_LOBW 2'h0
`define CB_MODE_BYP 2'h1
`define CB_MODE_HIBW 2'h3
// timing
`define CB_STRAP_WAIT 2'h3
`define CB_LAST_BIT 4'h8
`define CB_CLK_NS 4
`define CB_SCL_NS 160
`define CB_QUARTER (`CB_SCL_NS / (4 * `CB_CLK_NS))
`endif

/* File: verilog/cb_pkg.sv */
// state and step types for the clock buffer management port
package cb_pkg;
  typedef enum logic [2:0] {D_IDLE = 3'h0, D_RX = 3'h1, D_RACK = 3'h2, D_TX = 3'h3,
    D_TACK = 3'h4} cb_dstate_t;
  typedef enum logic [1:0] {ST_ADDR = 2'h0, ST_INDEX = 2'h1, ST_COUNT = 2'h2,
    ST_DATA = 2'h3} cb_step_t;
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_START = 2'h1, H_BITS = 2'h2,
    H_STOP = 2'h3} cb_hstate_t;
  typedef enum logic [2:0] {HB_AW = 3'h0, HB_IDX = 3'h1, HB_CNT = 3'h2, HB_WD = 3'h3,
    HB_AR = 3'h4, HB_RC = 3'h5, HB_RD = 3'h6} cb_hstep_t;
endpackage

/* File: verilog/cb_if.sv */
// two-wire management link joining host and target
`timescale 1ns/100ps
interface cb_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-up: any enabled low driver wins
  assign scl = (scl_oe && !scl_o) ? 1'h0 : 1'h1;
  assign sda = ((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o)) ? 1'h0 : 1'h1;
  modport host (output scl_o, output scl_oe, output sda_h_o, output sda_h_oe,
    input scl, input sda);
  modport target (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface

/* File: verilog/cb_target.sv */
// management port target with the configuration register bank
`timescale 1ns/100ps
`include "cb_params.svh"
module cb_target
  import cb_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  cb_if.target BUS,
  input wire logic [1:0] ADDR_PIN,
  input wire logic [1:0] MODE_PIN,
  input wire logic [7:0] OE_PIN_N,
  input wire logic REF_RUNNING,
  output logic [7:0] OUT_RUN,
  output logic [1:0] PLL_MODE,
  output logic [1:0] AMPLITUDE,
  output logic [7:0] EDGE_RATE,
  output logic FB_EDGE_RATE
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [14:0] meta_reg;
  logic [14:0] sync_reg;
  logic scl_s;
  logic sda_s;
  logic ref_run;
  logic [7:0] oe_pin_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [1:0] strap_cnt_reg;
  logic [1:0] addr_sel_reg;
  logic [1:0] pin_mode_reg;
  logic [6:0] my_addr;
  cb_dstate_t state_reg;
  cb_step_t step_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic rd_reg;
  logic [7:0] ptr_reg;
  logic sda_oe_reg;
  logic wr_stb;
  logic [7:0] rdata;
  logic [7:0] oe_mask_reg;
  logic sw_mode_reg;
  logic [1:0] mode_ctl_reg;
  logic [1:0] amp_reg;
  logic [7:0] edge_reg;
  logic fb_edge_reg;
  logic [4:0] len_reg;

  // every pin input, bus lines included, passes two flops before use
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      meta_reg <= 15'h7FFF;
      sync_reg <= 15'h7FFF;
    end
    else
    begin
      meta_reg <= {REF_RUNNING, OE_PIN_N, MODE_PIN, ADDR_PIN, BUS.sda, BUS.scl};
      sync_reg <= meta_reg;
    end

  assign scl_s = sync_reg[0];
  assign sda_s = sync_reg[1];
  assign oe_pin_s = sync_reg[13:6];
  assign ref_run = sync_reg[14];

  // previous synced levels for edge and condition detection
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end

  // bus events are ignored while the reference clock is stopped
  assign scl_rise = ref_run && scl_s && !scl_d_reg;
  assign scl_fall = ref_run && !scl_s && scl_d_reg;
  assign start_ev = ref_run && scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_ev = ref_run && scl_s && scl_d_reg && !sda_d_reg && sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // straps are caught once the synchronisers hold real pin levels, then frozen
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      strap_cnt_reg <= 2'h0;
      addr_sel_reg <= 2'h0;
      pin_mode_reg <= 2'h0;
    end
    else if (strap_cnt_reg != `CB_STRAP_WAIT)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      addr_sel_reg <= sync_reg[3:2];
      pin_mode_reg <= sync_reg[5:4];
    end

  // the latched select level picks one of three addresses
  always_comb
    if (addr_sel_reg == `CB_PIN_LO)
      my_addr = `CB_ADDR_LO;
    else if (addr_sel_reg == `CB_PIN_MID)
      my_addr = `CB_ADDR_MID;
    else
      my_addr = `CB_ADDR_HI;

  ////////////////////////////////////////////////////////////////////////////////
  // byte engine: receive on rising edges, drive and release on falling edges
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      state_reg <= D_IDLE;
      step_reg <= ST_ADDR;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rd_reg <= 1'h0;
      ptr_reg <= 8'h00;
      sda_oe_reg <= 1'h0;
    end
    else if (stop_ev || !ref_run)
    begin
      state_reg <= D_IDLE;
      sda_oe_reg <= 1'h0;
    end
    else if (start_ev)
    begin
      // a repeated start keeps the index pointer for the read that follows
      state_reg <= D_RX;
      step_reg <= ST_ADDR;
      bit_reg <= 4'h0;
      sda_oe_reg <= 1'h0;
    end
    else
      case (state_reg)
        D_RX:
          if (scl_rise && bit_reg != `CB_LAST_BIT)
          begin
            sh_reg <= {sh_reg[6:0], sda_s};
            bit_reg <= bit_reg + 4'h1;
          end
          else if (scl_fall && bit_reg == `CB_LAST_BIT)
          begin
            // a foreign address gets no acknowledge and the target goes quiet
            if (step_reg == ST_ADDR && sh_reg[7:1] != my_addr)
              state_reg <= D_IDLE;
            else
            begin
              state_reg <= D_RACK;
              sda_oe_reg <= 1'h1;
              if (step_reg == ST_ADDR)
                rd_reg <= sh_reg[0];
              if (step_reg == ST_INDEX)
                ptr_reg <= sh_reg;
              if (step_reg == ST_DATA)
                ptr_reg <= ptr_reg + 8'h01;
            end
          end
        D_RACK:
          if (scl_fall)
          begin
            if (rd_reg)
            begin
              // the count goes out first, then registers from the index
              state_reg <= D_TX;
              step_reg <= ST_DATA;
              sh_reg <= {3'h0, len_reg};
              sda_oe_reg <= 1'h1; // the count's top bit is always zero, so pull low
              bit_reg <= 4'h1;
            end
            else
            begin
              state_reg <= D_RX;
              sda_oe_reg <= 1'h0;
              bit_reg <= 4'h0;
              if (step_reg == ST_ADDR)
                step_reg <= ST_INDEX;
              else if (step_reg == ST_INDEX)
                step_reg <= ST_COUNT;
              else
                step_reg <= ST_DATA;
            end
          end
        D_TX:
          if (scl_fall)
          begin
            if (bit_reg == `CB_LAST_BIT)
            begin
              state_reg <= D_TACK;
              sda_oe_reg <= 1'h0;
            end
            else
            begin
              sh_reg <= {sh_reg[6:0], 1'h0};
              sda_oe_reg <= !sh_reg[6];
              bit_reg <= bit_reg + 4'h1;
            end
          end
        D_TACK:
          if (scl_rise && sda_s)
            state_reg <= D_IDLE;
          else if (scl_fall)
          begin
            state_reg <= D_TX;
            sh_reg <= rdata;
            sda_oe_reg <= !rdata[7];
            ptr_reg <= ptr_reg + 8'h01;
            bit_reg <= 4'h1;
          end
        default:
          state_reg <= D_IDLE;
      endcase

  assign BUS.sda_d_o = 1'h0;
  assign BUS.sda_d_oe = sda_oe_reg;

  // a data byte of a write lands at the pointer in its final falling edge
  assign wr_stb = state_reg == D_RX && scl_fall && bit_reg == `CB_LAST_BIT &&
    step_reg == ST_DATA && !rd_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // writable registers; indices past the bank ignore writes
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      oe_mask_reg <= `CB_OE_RST;
      sw_mode_reg <= 1'h0;
      mode_ctl_reg <= `CB_MODE_LOBW;
      amp_reg <= `CB_AMP_RST;
      edge_reg <= `CB_EDGE_RST;
      fb_edge_reg <= 1'h1;
      len_reg <= `CB_LEN_RST;
    end
    else if (wr_stb)
    begin
      if (ptr_reg == `CB_REG_OE)
        oe_mask_reg <= sh_reg;
      else if (ptr_reg == `CB_REG_MODE)
      begin
        sw_mode_reg <= sh_reg[5];
        mode_ctl_reg <= sh_reg[4:3];
        amp_reg <= sh_reg[1:0];
      end
      else if (ptr_reg == `CB_REG_EDGE)
        edge_reg <= sh_reg;
      else if (ptr_reg == `CB_REG_FB)
        fb_edge_reg <= sh_reg[0];
      else if (ptr_reg == `CB_REG_LEN)
        len_reg <= sh_reg[4:0];
    end

  // read view; unmapped indices read as zero
  always_comb
    if (ptr_reg == `CB_REG_OE)
      rdata = oe_mask_reg;
    else if (ptr_reg == `CB_REG_MODE)
      rdata = {pin_mode_reg, sw_mode_reg, mode_ctl_reg, `CB_MODE_RSV, amp_reg};
    else if (ptr_reg == `CB_REG_EDGE)
      rdata = edge_reg;
    else if (ptr_reg == `CB_REG_FB)
      rdata = {`CB_FB_RSV, fb_edge_reg};
    else if (ptr_reg == `CB_REG_RSV)
      rdata = `CB_ALL_ONES;
    else if (ptr_reg == `CB_REG_REV)
      rdata = {`CB_REV_CODE, `CB_MAKER_CODE};
    else if (ptr_reg == `CB_REG_DEV)
      rdata = {`CB_CLASS_CODE, `CB_PART_CODE};
    else if (ptr_reg == `CB_REG_LEN)
      rdata = {3'h0, len_reg};
    else
      rdata = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // output controls; enable pins take two sync flops plus this one, so three clocks
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      OUT_RUN <= 8'h00;
      PLL_MODE <= `CB_MODE_LOBW;
      AMPLITUDE <= `CB_AMP_RST;
      EDGE_RATE <= `CB_EDGE_RST;
      FB_EDGE_RATE <= 1'h1;
    end
    else
    begin
      OUT_RUN <= oe_mask_reg & ~oe_pin_s & {8{ref_run}};
      PLL_MODE <= sw_mode_reg ? mode_ctl_reg : pin_mode_reg;
      AMPLITUDE <= amp_reg;
      EDGE_RATE <= edge_reg;
      FB_EDGE_RATE <= fb_edge_reg;
    end

endmodule

/* File: verilog/cb_host.sv */
// management port host issuing indexed block writes and reads
`timescale 1ns/100ps
`include "cb_params.svh"
module cb_host
  import cb_pkg::*;
#(
  parameter int QCYC = `CB_QUARTER
)
(
  input wire logic CLK,
  input wire logic NRST,
  cb_if.host BUS,
  input wire logic REQ,
  input wire logic REQ_RD,
  input wire logic [6:0] REQ_ADDR,
  input wire logic [7:0] REQ_INDEX,
  input wire logic [4:0] REQ_LEN,
  input wire logic [7:0] WR_DATA,
  output logic WR_TAKE,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic BUSY,
  output logic NACK_ERR
);

  ////////////////////////////////////////////////////////////////////////////////
  logic sda_meta_reg;
  logic sda_s_reg;
  logic [7:0] div_reg;
  logic qtick;
  logic [1:0] q_reg;
  logic [1:0] nq;
  cb_hstate_t state_reg;
  cb_hstep_t step_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic rd_reg;
  logic [6:0] addr_reg;
  logic [7:0] idx_reg;
  logic [4:0] len_reg;
  logic [4:0] left_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic txm;
  logic last_rx;

  // data line comes back through two flops; the clock is ours, no stretching
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      sda_meta_reg <= 1'h1;
      sda_s_reg <= 1'h1;
    end
    else
    begin
      sda_meta_reg <= BUS.sda;
      sda_s_reg <= sda_meta_reg;
    end

  // quarter-bit divider runs only during a transfer
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
      div_reg <= 8'h00;
    else if (state_reg == H_IDLE || qtick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;

  assign qtick = div_reg == 8'(QCYC - 1);
  assign nq = q_reg + 2'h1;
  assign txm = step_reg != HB_RC && step_reg != HB_RD;
  assign last_rx = (step_reg == HB_RC && len_reg == 5'h00) ||
    (step_reg == HB_RD && left_reg == 5'h01);

  ////////////////////////////////////////////////////////////////////////////////
  // quarter 0 drops the clock, 1 sets data, 2 raises the clock, 3 samples
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      state_reg <= H_IDLE;
      step_reg <= HB_AW;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rd_reg <= 1'h0;
      addr_reg <= 7'h00;
      idx_reg <= 8'h00;
      len_reg <= 5'h00;
      left_reg <= 5'h00;
      scl_low_reg <= 1'h0;
      sda_low_reg <= 1'h0;
      WR_TAKE <= 1'h0;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'h0;
      NACK_ERR <= 1'h0;
    end
    else
    begin
      WR_TAKE <= 1'h0;
      RD_VALID <= 1'h0;
      if (state_reg == H_IDLE)
      begin
        if (REQ)
        begin
          state_reg <= H_START;
          step_reg <= HB_AW;
          q_reg <= 2'h3;
          bit_reg <= 4'h0;
          sh_reg <= {REQ_ADDR, 1'h0};
          rd_reg <= REQ_RD;
          addr_reg <= REQ_ADDR;
          idx_reg <= REQ_INDEX;
          len_reg <= REQ_LEN;
          NACK_ERR <= 1'h0;
        end
      end
      else if (qtick)
      begin
        q_reg <= nq;
        if (nq == 2'h0)
          scl_low_reg <= 1'h1;
        else if (nq == 2'h2)
          scl_low_reg <= 1'h0;
        else if (nq == 2'h1)
        begin
          if (state_reg == H_START)
            sda_low_reg <= 1'h0;
          else if (state_reg == H_STOP)
            sda_low_reg <= 1'h1;
          else if (bit_reg != `CB_LAST_BIT)
            sda_low_reg <= txm && !sh_reg[7];
          else
            sda_low_reg <= !txm && !last_rx;
        end
        else if (state_reg == H_START)
        begin
          sda_low_reg <= 1'h1;
          state_reg <= H_BITS;
        end
        else if (state_reg == H_STOP)
        begin
          sda_low_reg <= 1'h0;
          state_reg <= H_IDLE;
        end
        else if (bit_reg != `CB_LAST_BIT)
        begin
          sh_reg <= {sh_reg[6:0], sda_s_reg};
          bit_reg <= bit_reg + 4'h1;
        end
        else
        begin
          // end of a byte frame: check the answer and pick the next byte
          bit_reg <= 4'h0;
          if (txm && sda_s_reg)
          begin
            NACK_ERR <= 1'h1;
            state_reg <= H_STOP;
          end
          else
            case (step_reg)
              HB_AW:
              begin
                step_reg <= HB_IDX;
                sh_reg <= idx_reg;
              end
              HB_IDX:
                if (rd_reg)
                begin
                  state_reg <= H_START;
                  step_reg <= HB_AR;
                  sh_reg <= {addr_reg, 1'h1};
                end
                else
                begin
                  step_reg <= HB_CNT;
                  sh_reg <= {3'h0, len_reg};
                end
              HB_CNT:
                if (len_reg == 5'h00)
                  state_reg <= H_STOP;
                else
                begin
                  step_reg <= HB_WD;
                  sh_reg <= WR_DATA;
                  WR_TAKE <= 1'h1;
                  left_reg <= len_reg;
                end
              HB_WD:
              begin
                left_reg <= left_reg - 5'h01;
                if (left_reg == 5'h01)
                  state_reg <= H_STOP;
                else
                begin
                  sh_reg <= WR_DATA;
                  WR_TAKE <= 1'h1;
                end
              end
              HB_AR:
                step_reg <= HB_RC;
              HB_RC:
              begin
                RD_DATA <= sh_reg;
                RD_VALID <= 1'h1;
                left_reg <= len_reg;
                if (len_reg == 5'h00)
                  state_reg <= H_STOP;
                else
                  step_reg <= HB_RD;
              end
              default:
              begin
                RD_DATA <= sh_reg;
                RD_VALID <= 1'h1;
                left_reg <= left_reg - 5'h01;
                if (left_reg == 5'h01)
                  state_reg <= H_STOP;
              end
            endcase
        end
      end
    end

  assign BUS.scl_o = 1'h0;
  assign BUS.scl_oe = scl_low_reg;
  assign BUS.sda_h_o = 1'h0;
  assign BUS.sda_h_oe = sda_low_reg;
  assign BUSY = state_reg != H_IDLE;

endmodule

/* File: dv/cb_properties.sv */
// link checker for the two-wire port between host and target
`timescale 1ns/100ps
module cb_properties
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb_clk @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////
  // open drain: an enabled driver only ever pulls low
  a_scl_pull_low: assert property (scl_oe |-> !scl_o)
    else $error("host drives clock high");
  a_host_sda_low: assert property (sda_h_oe |-> !sda_h_o)
    else $error("host drives data high");
  a_target_sda_low: assert property (sda_d_oe |-> !sda_d_o)
    else $error("target drives data high");
  // both ends let go of the wires as reset ends
  a_reset_bus_free: assert property ($rose(NRST) |-> !scl_oe && !sda_h_oe && !sda_d_oe)
    else $error("bus held at reset release");
  // target moves data three clocks into the low phase, never while the clock is high
  a_ack_after_fall: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl, 2))
    else $error("target data moved outside low phase");
  // start and stop edges only come from the host with the target quiet
  a_quiet_at_frame: assert property (scl && $past(scl) && $changed(sda)
    |-> !sda_d_oe && !$past(sda_d_oe))
    else $error("target busy at start or stop");
  // each clock phase spans two quarters, so a glitch here breaks framing
  a_scl_low_span: assert property ($fell(scl) |=> !scl [*6])
    else $error("clock low phase too short");
  a_scl_high_span: assert property ($rose(scl) |=> scl [*6])
    else $error("clock high phase too short");
endmodule

/* File: dv/tb_smbus_clock_buffer_config_regs.sv */
// self-checking bench: host and target joined over the two-wire link
`timescale 1ns/100ps
`include "cb_params.svh"
module tb_smbus_clock_buffer_config_regs;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic req = 1'h0;
  logic req_rd = 1'h0;
  logic ref_run = 1'h1;
  logic [6:0] req_addr = `CB_ADDR_LO;
  logic [7:0] req_index = 8'h00;
  logic [4:0] req_len = 5'h00;
  logic [1:0] addr_pin = `CB_PIN_LO;
  logic [1:0] mode_pin = `CB_MODE_HIBW;
  logic [7:0] oe_pin_n = 8'h00;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:15];
  int wptr = 0;
  int rptr = 0;
  logic wr_take;
  logic rd_valid;
  logic busy;
  logic nack_err;
  logic fb_edge;
  logic [7:0] rd_data;
  logic [7:0] out_run;
  logic [7:0] edge_rate;
  logic [1:0] pll_mode;
  logic [1:0] amplitude;
  int err_count = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  cb_if u_cb_if ();
  cb_host #(.QCYC(4)) u_cb_host (.CLK(clk), .NRST(nrst), .BUS(u_cb_if), .REQ(req),
    .REQ_RD(req_rd), .REQ_ADDR(req_addr), .REQ_INDEX(req_index), .REQ_LEN(req_len),
    .WR_DATA(wbuf[wptr]), .WR_TAKE(wr_take), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .BUSY(busy), .NACK_ERR(nack_err));
  cb_target u_cb_target (.CLK(clk), .NRST(nrst), .BUS(u_cb_if), .ADDR_PIN(addr_pin),
    .MODE_PIN(mode_pin), .OE_PIN_N(oe_pin_n), .REF_RUNNING(ref_run), .OUT_RUN(out_run),
    .PLL_MODE(pll_mode), .AMPLITUDE(amplitude), .EDGE_RATE(edge_rate),
    .FB_EDGE_RATE(fb_edge));
  cb_properties u_cb_properties (.CLK(clk), .NRST(nrst), .scl_o(u_cb_if.scl_o),
    .scl_oe(u_cb_if.scl_oe), .sda_h_o(u_cb_if.sda_h_o), .sda_h_oe(u_cb_if.sda_h_oe),
    .sda_d_o(u_cb_if.sda_d_o), .sda_d_oe(u_cb_if.sda_d_oe), .scl(u_cb_if.scl),
    .sda(u_cb_if.sda));
  // next write byte advances on each take; read bytes land in order, count first
  always @(posedge clk)
  begin
    if (wr_take === 1'h1)
      wptr <= wptr + 1;
    if (rd_valid === 1'h1)
    begin
      rbuf[rptr] <= rd_data;
      rptr <= rptr + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one whole block transfer; the tail lets register writes reach the outputs
  task xfer(input logic rd, input logic [7:0] idx, input logic [4:0] len);
    int n;
    wptr = 0;
    rptr = 0;
    req = 1'h1;
    req_rd = rd;
    req_index = idx;
    req_len = len;
    @(posedge clk);
    #1;
    req = 1'h0;
    n = 0;
    while (busy !== 1'h0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    // a transfer that never ends counts against the run
    chk("busy", 8'h00, {7'h0, busy});
    repeat (4) @(posedge clk);
    #1;
  endtask
  task t_defaults;
    chk("pll_mode", {6'h0, `CB_MODE_HIBW}, {6'h0, pll_mode});
    chk("amp", {6'h0, `CB_AMP_RST}, {6'h0, amplitude});
    chk("out_run", 8'hFF, out_run);
    xfer(1'h1, `CB_REG_OE, 5'h08);
    chk("count", {3'h0, `CB_LEN_RST}, rbuf[0]);
    chk("oe", `CB_OE_RST, rbuf[1]);
    chk("mode", {`CB_MODE_HIBW, 3'h0, `CB_MODE_RSV, `CB_AMP_RST}, rbuf[2]);
    chk("edge", `CB_EDGE_RST, rbuf[3]);
    chk("fb", {`CB_FB_RSV, 1'h1}, rbuf[4]);
    chk("rsv", `CB_ALL_ONES, rbuf[5]);
    chk("rev", {`CB_REV_CODE, `CB_MAKER_CODE}, rbuf[6]);
    chk("dev", {`CB_CLASS_CODE, `CB_PART_CODE}, rbuf[7]);
    chk("len", {3'h0, `CB_LEN_RST}, rbuf[8]);
    $display("t_defaults done");
  endtask
  task t_write;
    wbuf = '{8'h5A, 8'h2F, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    xfer(1'h0, `CB_REG_OE, 5'h04);
    chk("nack", 8'h00, {7'h0, nack_err});
    chk("out_run", 8'h5A, out_run);
    chk("pll_mode", {6'h0, `CB_MODE_BYP}, {6'h0, pll_mode});
    chk("amp", 8'h03, {6'h0, amplitude});
    chk("edge", 8'h3C, edge_rate);
    chk("fb", 8'h00, {7'h0, fb_edge});
    xfer(1'h1, `CB_REG_MODE, 5'h03);
    chk("mode_rb", 8'hEF, rbuf[1]);
    chk("edge_rb", 8'h3C, rbuf[2]);
    chk("fb_rb", {`CB_FB_RSV, 1'h0}, rbuf[3]);
    $display("t_write done");
  endtask
  task t_modes;
    logic [1:0] codes [0:2];
    codes = '{`CB_MODE_LOBW, `CB_MODE_BYP, `CB_MODE_HIBW};
    for (int i = 0; i < 3; i++)
    begin
      wbuf[0] = {3'h1, codes[i], 1'h1, i[1:0]};
      xfer(1'h0, `CB_REG_MODE, 5'h01);
      chk("pll_mode", {6'h0, codes[i]}, {6'h0, pll_mode});
      chk("amp", {6'h0, i[1:0]}, {6'h0, amplitude});
    end
    // soft code left at bypass while the override is off must not count
    wbuf[0] = 8'h0F;
    xfer(1'h0, `CB_REG_MODE, 5'h01);
    chk("pll_mode", {6'h0, mode_pin}, {6'h0, pll_mode});
    $display("t_modes done");
  endtask
  task t_readonly;
    wbuf = '{8'h00, 8'h00, 8'h00, 8'hE3, 8'h00, 8'h00, 8'h00, 8'h00};
    xfer(1'h0, `CB_REG_RSV, 5'h04);
    xfer(1'h1, `CB_REG_RSV, 5'h04);
    chk("count", 8'h03, rbuf[0]);
    chk("rsv", `CB_ALL_ONES, rbuf[1]);
    chk("rev", {`CB_REV_CODE, `CB_MAKER_CODE}, rbuf[2]);
    chk("dev", {`CB_CLASS_CODE, `CB_PART_CODE}, rbuf[3]);
    chk("len", 8'h03, rbuf[4]);
    $display("t_readonly done");
  endtask
  task t_address;
    // the select pin moves after its level was latched; the old address must hold
    addr_pin = `CB_PIN_MID;
    req_addr = `CB_ADDR_MID;
    wbuf[0] = 8'h00;
    xfer(1'h0, `CB_REG_OE, 5'h01);
    chk("nack", 8'h01, {7'h0, nack_err});
    chk("out_run", 8'h5A, out_run);
    req_addr = `CB_ADDR_LO;
    wbuf[0] = 8'hFF;
    xfer(1'h0, `CB_REG_OE, 5'h01);
    chk("nack", 8'h00, {7'h0, nack_err});
    $display("t_address done");
  endtask
  task t_pins;
    oe_pin_n = 8'h0F;
    repeat (3) @(posedge clk);
    #1;
    chk("out_run", 8'hF0, out_run);
    oe_pin_n = 8'h00;
    ref_run = 1'h0;
    wbuf[0] = 8'h00;
    xfer(1'h0, `CB_REG_OE, 5'h01);
    chk("nack", 8'h01, {7'h0, nack_err});
    chk("out_run", 8'h00, out_run);
    ref_run = 1'h1;
    xfer(1'h1, `CB_REG_OE, 5'h01);
    chk("oe_rb", 8'hFF, rbuf[1]);
    $display("t_pins done");
  endtask
  task t_reset;
    // a second reset must catch the select and mode pins afresh
    addr_pin = `CB_PIN_HI;
    mode_pin = `CB_MODE_LOBW;
    nrst = 1'h0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'h1;
    repeat (30) @(posedge clk);
    #1;
    chk("pll_mode", {6'h0, `CB_MODE_LOBW}, {6'h0, pll_mode});
    chk("out_run", `CB_OE_RST, out_run);
    req_addr = `CB_ADDR_HI;
    xfer(1'h1, `CB_REG_MODE, 5'h01);
    chk("nack", 8'h00, {7'h0, nack_err});
    chk("mode_rb", {`CB_MODE_LOBW, 3'h0, `CB_MODE_RSV, `CB_AMP_RST}, rbuf[1]);
    $display("t_reset done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'h1;
    repeat (30) @(posedge clk);
    #1;
    t_defaults;
    t_write;
    t_modes;
    t_readonly;
    t_address;
    t_pins;
    t_reset;
    print_verdict;
  end
  // the whole run needs well under a third of this span
  initial
  begin
    #300000;
    err_count++;
    $display("Error watchdog expected done seen hang");
    print_verdict;
  end
endmodule
